// file: logic/fecs_syscall.sv
module fecs_syscall (
    input wire logic pclk, // Clock, 10 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic requester_secure, // Security of the requesting master
    output fecs_pkg::fecs_mem_req_type sram_req, // Parameter block port
    input wire fecs_pkg::fecs_mem_rsp_type sram_rsp, // Parameter block answer
    output fecs_pkg::fecs_mem_req_type flash_req, // Flash read port
    input wire fecs_pkg::fecs_mem_rsp_type flash_rsp, // Flash read answer
    output logic erase_strobe, // Erase pulse to flash macro
    output logic hv_hw_timed, // High-voltage cycles timed by hardware
    output logic read_stall, // Stall all flash reads
    output logic busy, // Operation running
    output logic fault_exception, // Protection fault
    output logic irq // Interrupt, high level
);
    import fecs_pkg::*;
    typedef struct packed {
        fecs_phase_type phase;
        logic [31:0] cmd;
        logic [31:0] args;
        logic [31:0] result;
        logic from_block;
        // Flash walk: region base, word index and last index
        logic [31:0] base;
        logic [FLASH_AW-1:0] addr;
        logic [FLASH_AW-1:0] last;
        logic [3:0] wait_cnt;
        // Software-visible registers
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic [FLASH_AW-1:0] macro_words;
        // Registered outputs
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        fecs_mem_req_type sram_req;
        fecs_mem_req_type flash_req;
        logic erase_strobe;
        logic hv_hw_timed;
        logic read_stall;
        logic busy;
        logic fault_exception;
        logic irq;
        logic sum_clear;
    } fecs_state_type;
    fecs_state_type r, next_r;
    // Byte sum of the words read during a checksum walk
    logic [23:0] sum;
    logic sum_add;
    logic apb_write;
    logic apb_read;
    logic [2:0] events;
    logic [31:0] region_base;
    // A transfer is acted on once, in the cycle before pready goes out
    assign apb_write = psel && penable && pwrite && !r.pready;
    assign apb_read = psel && penable && !pwrite && !r.pready;
    // Only a clean flash answer during a checksum adds to the sum
    assign sum_add = r.phase == SUM && r.flash_req.req && flash_rsp.ack && !flash_rsp.fault;
    always_comb begin
        next_r = r;
        events = 3'h0;
        region_base = 32'h00000000;
        next_r.pready = psel && penable && !r.pready;
        next_r.pslverr = 1'b0;
        next_r.erase_strobe = 1'b0;
        next_r.sum_clear = 1'b0;
        // Register writes; a command while busy is refused with pslverr
        if (apb_write) begin
            unique case (paddr)
                OFS_COMMAND: begin
                    if (r.busy) begin
                        next_r.pslverr = 1'b1;
                    end else begin
                        next_r.cmd = pwdata; // RULE_11
                        next_r.phase = pwdata[BIT_DIRECT] ? DECODE : FETCH; // RULE_04
                        next_r.from_block = !pwdata[BIT_DIRECT]; // RULE_07
                        next_r.args = pwdata;
                        next_r.busy = 1'b1;
                    end
                end
                OFS_IRQ_STATUS: next_r.irq_status = r.irq_status & ~pwdata[2:0];
                OFS_IRQ_MASK: next_r.irq_mask = pwdata[2:0];
                OFS_CONFIG: next_r.macro_words = pwdata[FLASH_AW-1:0];
                OFS_CONTROL, OFS_STATUS: ;
                default: next_r.pslverr = 1'b1;
            endcase
        end
        // Register reads land in prdata together with pready
        if (apb_read) begin
            unique case (paddr)
                OFS_COMMAND: next_r.prdata = r.result; // RULE_11
                OFS_STATUS: next_r.prdata = {29'h0, r.read_stall, r.hv_hw_timed, r.busy};
                OFS_IRQ_STATUS: next_r.prdata = {29'h0, r.irq_status};
                OFS_IRQ_MASK: next_r.prdata = {29'h0, r.irq_mask};
                OFS_CONFIG: next_r.prdata = {16'h0, r.macro_words};
                OFS_CONTROL: next_r.prdata = r.cmd;
                default: begin
                    next_r.prdata = 32'h00000000;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        // Writing one to the fault bit drops the pin; a fault raised below still wins
        if (apb_write && paddr == OFS_IRQ_STATUS && pwdata[2]) begin
            next_r.fault_exception = 1'b0;
        end
        // Command sequencer
        unique case (r.phase)
            IDLE: begin
                // No request may linger once a command has finished
                next_r.sram_req.req = 1'b0;
                next_r.flash_req.req = 1'b0;
            end
            // CPU request: fetch the argument word from the parameter block
            FETCH: begin
                next_r.sram_req.req = 1'b1;
                next_r.sram_req.wr = 1'b0;
                next_r.sram_req.addr = {r.cmd[31:2], 2'b00}; // RULE_07
                if (r.sram_req.req && sram_rsp.ack) begin
                    next_r.sram_req.req = 1'b0;
                    next_r.args = sram_rsp.rdata;
                    next_r.phase = DECODE;
                end
            end
            // Options come from the command word or from the fetched block word
            DECODE: begin
                next_r.sum_clear = 1'b1;
                next_r.hv_hw_timed = r.args[BIT_HW_TIMED]; // RULE_06
                unique case (r.args[OPC_MSB:OPC_LSB])
                    OP_ERASE_ALL: begin
                        next_r.read_stall = r.args[BIT_STALL]; // RULE_05
                        next_r.erase_strobe = 1'b1; // RULE_02
                        next_r.wait_cnt = ERASE_CYCLES;
                        next_r.phase = ERASE;
                    end
                    OP_CHECKSUM: begin
                        unique case (r.args[REG_MSB:REG_LSB]) // RULE_09
                            REGION_APP: region_base = BASE_APP;
                            REGION_AUX: region_base = BASE_AUX;
                            default: region_base = BASE_SUPERVISORY;
                        endcase
                        if (r.args[BIT_WHOLE]) begin
                            next_r.addr = '0;
                            next_r.last = r.macro_words - 16'h0001;
                        end else begin
                            next_r.addr = FLASH_AW'({r.args[ROW_MSB:ROW_LSB], 3'b000});
                            next_r.last = FLASH_AW'({r.args[ROW_MSB:ROW_LSB], 3'b111});
                        end
                        // Base is held apart from the index so it lasts the whole walk
                        next_r.base = region_base; // RULE_09
                        next_r.phase = SUM;
                    end
                    default: begin
                        next_r.result = {STAT_ERROR, ERR_BAD_OPCODE}; // RULE_14
                        next_r.phase = WRITEBACK;
                    end
                endcase
            end
            // High-voltage time, then verify from the first word of the main array
            ERASE: begin
                if (r.wait_cnt == 4'h0) begin
                    next_r.addr = '0;
                    next_r.last = r.macro_words - 16'h0001;
                    next_r.base = BASE_APP; // RULE_02
                    next_r.phase = VERIFY;
                end else begin
                    next_r.wait_cnt = r.wait_cnt - 4'h1;
                end
            end
            // One read in flight at a time; the request stands until ack
            VERIFY, SUM: begin
                next_r.flash_req.req = 1'b1;
                next_r.flash_req.wr = 1'b0;
                next_r.flash_req.addr = r.base + {14'h0, r.addr, 2'b00};
                if (r.flash_req.req && flash_rsp.ack) begin
                    next_r.flash_req.req = 1'b0;
                    if (r.phase == SUM && flash_rsp.fault) begin
                        next_r.fault_exception = !requester_secure; // RULE_10
                        next_r.result = {STAT_ERROR, ERR_PROTECTION};
                        next_r.phase = WRITEBACK;
                    end else if (r.phase == VERIFY && flash_rsp.rdata != 32'h00000000) begin
                        next_r.result = {STAT_ERROR, ERR_VERIFY_NONZERO}; // RULE_03
                        next_r.phase = WRITEBACK;
                    end else if (r.addr == r.last) begin
                        next_r.phase = FINISH;
                    end else begin
                        next_r.addr = r.addr + 16'h0001;
                    end
                end
            end
            // Success word: checksum in the low bits, or a plain success code
            FINISH: begin
                if (r.args[OPC_MSB:OPC_LSB] == OP_CHECKSUM) begin
                    next_r.result = {STAT_SUCCESS, 4'h0, sum}; // RULE_13
                end else begin
                    next_r.result = {STAT_SUCCESS, ERR_NONE}; // RULE_01
                end
                next_r.phase = WRITEBACK;
            end
            // Result stays in the command word; a CPU request also gets it in its block
            WRITEBACK: begin
                if (r.from_block) begin
                    next_r.sram_req.req = 1'b1;
                    next_r.sram_req.wr = 1'b1;
                    next_r.sram_req.wdata = r.result; // RULE_11
                end
                if (!r.from_block || (r.sram_req.req && sram_rsp.ack)) begin
                    next_r.sram_req.req = 1'b0;
                    next_r.busy = 1'b0;
                    next_r.read_stall = 1'b0;
                    next_r.phase = IDLE;
                    events = IRQ_DONE;
                    if (r.result[31:28] == STAT_ERROR) begin
                        events = events | IRQ_ERROR; // RULE_01
                    end
                    if (r.fault_exception) begin
                        events = events | IRQ_FAULT;
                    end
                end
            end
            default: next_r.phase = IDLE;
        endcase
        // An event in the cycle of a clear keeps its bit set
        next_r.irq_status = next_r.irq_status | events;
        next_r.irq = |(next_r.irq_status & r.irq_mask);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.phase <= IDLE;
            r.macro_words <= MACRO_WORDS_RESET;
        end else begin
            r <= next_r;
        end
    end
    fecs_byte_sum u_sum (
        .pclk(pclk),
        .presetn(presetn),
        .clear(r.sum_clear),
        .add(sum_add),
        .word(flash_rsp.rdata),
        .sum(sum)
    );
    // Every output comes straight from the state register
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign sram_req = r.sram_req;
    assign flash_req = r.flash_req;
    assign erase_strobe = r.erase_strobe;
    assign hv_hw_timed = r.hv_hw_timed;
    assign read_stall = r.read_stall;
    assign busy = r.busy;
    assign fault_exception = r.fault_exception;
    assign irq = r.irq;
endmodule // fecs_syscall

// file: logic/fecs_pkg.sv
// What this block does
// RULE_01: Result word top nibble: 0xA success or background program, 0xF error.
// RULE_02: Opcode 0x0A erases the whole main array of the macro only.
// RULE_03: After erase every word must read zero, else erase-verify-nonzero error.
// RULE_04: Debug master sets bit 0; arguments then come from the command word.
// RULE_05: Erase bit 2 zero lets other reads run; one stalls all reads.
// RULE_06: Bit 1 picks firmware-timed (0) or hardware-timed (1) high-voltage cycles.
// RULE_07: CPU master gives an aligned 32-bit pointer to its parameter block.
// RULE_08: Opcode 0x0B sums all bytes of one row or the whole region.
// RULE_09: Checksum bits 23:22 region, bit 21 row or whole, bits 20:8 row.
// RULE_10: Checksum runs with requester security; non-secure over secured flash faults.
// RULE_11: Requests arrive in the command word; results return there or in block.
// RULE_12: Low-voltage software raises supply and sets voltage flag around flash writes.
// RULE_13: Successful checksum returns its 24-bit sum in result bits 23:0.
// RULE_14: Unknown opcode does nothing and returns the error status nibble; the code still loads hv_hw_timed from bit 1.
package fecs_pkg;
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_CONFIG = 8'h14;
    localparam logic [7:0] OP_ERASE_ALL = 8'h0A;
    localparam logic [7:0] OP_CHECKSUM = 8'h0B;
    localparam logic [3:0] STAT_SUCCESS = 4'hA;
    localparam logic [3:0] STAT_ERROR = 4'hF;
    localparam logic [27:0] ERR_NONE = 28'h0000000;
    localparam logic [27:0] ERR_VERIFY_NONZERO = 28'h0000001;
    localparam logic [27:0] ERR_BAD_OPCODE = 28'h0000002;
    localparam logic [27:0] ERR_PROTECTION = 28'h0000003;
    localparam int OPC_MSB = 31;
    localparam int OPC_LSB = 24;
    localparam int BIT_STALL = 2;
    localparam int BIT_HW_TIMED = 1;
    localparam int BIT_DIRECT = 0;
    localparam int REG_MSB = 23;
    localparam int REG_LSB = 22;
    localparam int BIT_WHOLE = 21;
    localparam int ROW_MSB = 20;
    localparam int ROW_LSB = 8;
    localparam int ROW_WORDS_LOG2 = 3;
    localparam int FLASH_AW = 16;
    localparam logic [1:0] REGION_APP = 2'h0;
    localparam logic [1:0] REGION_AUX = 2'h1;
    localparam logic [31:0] BASE_APP = 32'h00000000;
    localparam logic [31:0] BASE_AUX = 32'h00010000;
    localparam logic [31:0] BASE_SUPERVISORY = 32'h00020000;
    localparam logic [15:0] MACRO_WORDS_RESET = 16'h0100;
    localparam logic [2:0] IRQ_DONE = 3'h1;
    localparam logic [2:0] IRQ_ERROR = 3'h2;
    localparam logic [2:0] IRQ_FAULT = 3'h4;
    localparam logic [3:0] ERASE_CYCLES = 4'h8;
    typedef enum {IDLE, FETCH, DECODE, ERASE, VERIFY, SUM, WRITEBACK, FINISH} fecs_phase_type;
    typedef struct packed {
        logic req;
        logic wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } fecs_mem_req_type;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic fault;
    } fecs_mem_rsp_type;
endpackage

// file: logic/fecs_byte_sum.sv
module fecs_byte_sum (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic clear, // Restart the sum
    input wire logic add, // Accumulate word
    input wire logic [31:0] word, // Word read from flash
    output logic [23:0] sum // Running byte sum
);
    import fecs_pkg::*;
    typedef struct packed {
        logic [23:0] sum;
    } fecs_sum_state_type;
    fecs_sum_state_type r, next_r;
    always_comb begin
        next_r = r;
        if (clear) begin
            next_r.sum = 24'h000000;
        end else if (add) begin
            next_r.sum = r.sum + 24'(word[7:0]) + 24'(word[15:8]) + 24'(word[23:16]) + 24'(word[31:24]); // RULE_08
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign sum = r.sum;
endmodule // fecs_byte_sum

// file: testbench/fecs_syscall_properties.sv
module fecs_syscall_properties (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic [7:0] paddr, // Address
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic requester_secure, // Security
    input wire fecs_pkg::fecs_mem_req_type flash_req, // Flash request
    input wire fecs_pkg::fecs_mem_rsp_type flash_rsp, // Flash answer
    input wire logic erase_strobe, // Erase
    input wire logic read_stall, // Stall
    input wire logic busy, // Busy
    input wire logic fault_exception // Fault
);
    import fecs_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_wait; psel && penable && !pready |=> pready; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready missing");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_unmapped; psel && penable && !pready && paddr > 8'h14 |=> pslverr && pready; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error");
    property p_strobe; erase_strobe |=> !erase_strobe && busy; endproperty
    a_strobe: assert property (p_strobe) else $error("bad strobe");
    property p_stall; $rose(read_stall) |-> busy; endproperty
    a_stall: assert property (p_stall) else $error("stall idle");
    property p_hold; flash_req.req && !flash_rsp.ack |=> flash_req.req && $stable(flash_req.addr); endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_fault; $rose(fault_exception) |-> !requester_secure; endproperty
    a_fault: assert property (p_fault) else $error("fault secure");
    property p_flash_busy; flash_req.req |-> busy; endproperty
    a_flash_busy: assert property (p_flash_busy) else $error("flash idle");
    c_erase: cover property (erase_strobe);
    c_fault: cover property (fault_exception);
    c_err: cover property (pslverr);
endmodule // fecs_syscall_properties

// file: testbench/fecs_mem_model.sv
module fecs_mem_model (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire fecs_pkg::fecs_mem_req_type flash_req, // Flash request
    output fecs_pkg::fecs_mem_rsp_type flash_rsp, // Flash answer
    input wire fecs_pkg::fecs_mem_req_type sram_req, // Block request
    output fecs_pkg::fecs_mem_rsp_type sram_rsp, // Block answer
    input wire logic erase_strobe, // Erase
    input wire logic requester_secure, // Security
    input wire logic slow, // Answer late
    input wire logic stuck, // Word survives erase
    input wire logic supply_high // Write supply raised by software
);
    import fecs_pkg::*;
    logic [31:0] sram_mem [16];
    logic erased;
    logic [1:0] fwait, swait;
    // Idle answer data toggles so stale data never looks valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erased <= 1'b0;
            fwait <= 2'h0;
            swait <= 2'h0;
            flash_rsp <= '0;
            sram_rsp <= '0;
        end else begin
            erased <= erased | (erase_strobe && supply_high);
            fwait <= flash_req.req && !flash_rsp.ack ? fwait + 2'h1 : 2'h0;
            swait <= sram_req.req && !sram_rsp.ack ? swait + 2'h1 : 2'h0;
            flash_rsp <= {1'b0, ~flash_rsp.rdata, 1'b0};
            sram_rsp <= {1'b0, ~sram_rsp.rdata, 1'b0};
            if (flash_req.req && !flash_rsp.ack && fwait == {slow, slow}) begin
                flash_rsp.ack <= 1'b1;
                flash_rsp.fault <= flash_req.addr >= 32'h20000 && !requester_secure;
                flash_rsp.rdata <= erased && flash_req.addr < 32'h10000 && !(stuck && flash_req.addr[5:2] == 4'h1)
                    ? '0 : {flash_req.addr[15:0], flash_req.addr[15:0] ^ 16'hA5C3};
            end
            if (sram_req.req && !sram_rsp.ack && swait == {slow, slow}) begin
                sram_rsp.ack <= 1'b1;
                sram_rsp.rdata <= sram_mem[sram_req.addr[5:2]];
                if (sram_req.wr) sram_mem[sram_req.addr[5:2]] <= sram_req.wdata;
            end
        end
    end
endmodule // fecs_mem_model

// file: testbench/fecs_syscall_bench.sv
module fecs_syscall_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import fecs_pkg::*;
    localparam logic [31:0] WORDS = 32'h10;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic requester_secure = 1'b1, slow = 1'b0, stuck = 1'b0, msk = 1'b0, supply_high = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, erase_strobe, hv_hw_timed, read_stall, busy, fault_exception, irq;
    fecs_mem_req_type sram_req, flash_req;
    fecs_mem_rsp_type sram_rsp, flash_rsp;
    int err_count = 0, checks = 0, cycles = 0;
    `define CHK(n, x, g) begin checks++; if ((g) !== (x)) begin err_count++; $display("[FAIL] %s expected %h seen %h", n, x, g); end end
    fecs_syscall fecs_syscall_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .requester_secure, .sram_req, .sram_rsp, .flash_req, .flash_rsp, .erase_strobe, .hv_hw_timed,
        .read_stall, .busy, .fault_exception, .irq);
    fecs_mem_model fecs_mem_model_i (.pclk, .presetn, .flash_req, .flash_rsp, .sram_req, .sram_rsp, .erase_strobe,
        .requester_secure, .slow, .stuck, .supply_high);
    initial forever #50 pclk = ~pclk;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [23:0] exp_sum(input logic [1:0] rg, input logic wh, input logic [12:0] row,
        input logic er);
        logic [31:0] a, w;
        logic [23:0] s;
        s = '0;
        for (int i = 0; i < (wh ? WORDS : 8); i++) begin
            a = (rg == 2'h0 ? 32'h0 : rg == 2'h1 ? 32'h10000 : 32'h20000) + ((wh ? 32'h0 : 32'(row) * 8) + 32'(i)) * 4;
            w = er && a < 32'h10000 ? '0 : {a[15:0], a[15:0] ^ 16'hA5C3};
            s += w[31:24] + w[23:16] + w[15:8] + w[7:0];
        end
        return s;
    endfunction
    // CPU requests (k nonzero) pass a word pointer into the parameter block
    task automatic run(input logic [31:0] cmd, input int k, input logic poke, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        if (k != 0) fecs_mem_model_i.sram_mem[k] = cmd;
        apb(1'b1, OFS_COMMAND, k != 0 ? 32'(k * 4) : cmd, q, e);
        if (poke) begin
            apb(1'b1, OFS_COMMAND, 32'h0B000001, q, e);
            `CHK("busy_refused", 1'b1, e)
            apb(1'b0, OFS_STATUS, '0, q, e);
            `CHK("status_bits", {cmd[2:1], 1'b1}, q[2:0])
            `CHK("hv_pin", cmd[1], hv_hw_timed)
            `CHK("stall_pin", cmd[2], read_stall)
            `CHK("busy_pin", 1'b1, busy)
        end
        q = '0;
        while (q[2:0] == 3'h0) apb(1'b0, OFS_IRQ_STATUS, '0, q, e);
        repeat (2) @(posedge pclk);
        `CHK("irq_level", msk, irq)
        `CHK("fault_flag", exp == 32'hF0000003, fault_exception)
        `CHK("busy_done", 1'b0, busy)
        `CHK("stall_done", 1'b0, read_stall)
        apb(1'b0, OFS_COMMAND, '0, q, e);
        `CHK("result", exp, q)
        if (k != 0) `CHK("block_result", exp, fecs_mem_model_i.sram_mem[k])
        apb(1'b1, OFS_IRQ_STATUS, 32'h7, q, e);
        repeat (2) @(posedge pclk);
        `CHK("irq_cleared", 1'b0, irq)
        `CHK("fault_cleared", 1'b0, fault_exception)
        $display("test done: command %h", cmd);
    endtask
    initial begin
        logic [31:0] q, cmd;
        logic e, wh;
        logic [1:0] rg;
        logic [12:0] row;
        int k;
        k = $urandom(11051);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_CONFIG, '0, q, e);
        `CHK("config_reset", 32'h100, q)
        apb(1'b0, 8'h20, '0, q, e);
        `CHK("unmapped_error", 1'b1, e)
        apb(1'b1, OFS_CONFIG, WORDS, q, e);
        run(32'h55000001, 0, 1'b0, 32'hF0000002);
        msk = 1'b1;
        apb(1'b1, OFS_IRQ_MASK, 32'h7, q, e);
        for (int i = 0; i < 8; i++) begin
            rg = i < 4 ? 2'(i) : 2'($urandom);
            wh = i < 2 ? i[0] : 1'($urandom);
            row = i == 0 ? 13'hFF : 13'($urandom % 256);
            k = i % 2 ? 1 + $urandom % 7 : 0;
            slow <= 1'($urandom);
            cmd = {OP_CHECKSUM, rg, wh, row, 7'h0, k == 0};
            run(cmd, k, 1'b0, {8'hA0, exp_sum(rg, wh, row, 1'b0)});
        end
        requester_secure <= 1'b0;
        run({OP_CHECKSUM, 2'h2, 1'b0, 13'h3, 8'h01}, 0, 1'b0, 32'hF0000003);
        requester_secure <= 1'b1;
        supply_high <= 1'b1;
        run(32'h0A000007, 0, 1'b1, 32'hA0000000);
        stuck <= 1'b1;
        run(32'h0A000000, 3, 1'b1, 32'hF0000001);
        stuck <= 1'b0;
        supply_high <= 1'b0;
        run({OP_CHECKSUM, 2'h0, 1'b1, 13'h0, 8'h01}, 0, 1'b0, 32'hA0000000);
        run({OP_CHECKSUM, 2'h1, 1'b1, 13'h0, 8'h01}, 0, 1'b0, {8'hA0, exp_sum(2'h1, 1'b1, 13'h0, 1'b1)});
        tally_and_finish();
    end
endmodule // fecs_syscall_bench
bind fecs_syscall fecs_syscall_properties fecs_syscall_properties_i (.pclk, .presetn, .psel, .penable, .paddr,
    .pready, .pslverr, .requester_secure, .flash_req, .flash_rsp, .erase_strobe, .read_stall, .busy, .fault_exception);
